// ---- rtl/sdct_ctrl.sv ----
// Controller end: closed-page full-page bursts with refresh and self refresh.
// Behaviour
// RQ1: Read mask floats data two clocks later.
// RQ2: Write mask blocks the same-edge word.
// RQ3: Self refresh exit begins second edge after enable.
// RQ4: Wait a row cycle after exit.
// RQ5: Nanosecond limits round up to whole clocks.
// RQ6: Read terminate stops data after CAS latency.
// RQ7: Write terminate edge data is ignored.
// RQ8: Reactivate bank only after precharge time.
// RQ9: Column commands at least one clock apart.
// RQ10: Issue 2048 refreshes every 32 ms.
// RQ11: Counts derive from period and speed grade.
`timescale 1ns/1ps
`default_nettype none
module sdct_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  sdct_if.ctl pins,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [sdct_pkg::BANK_W-1:0] req_bank,
  input wire logic [sdct_pkg::ADDR_W-1:0] req_row,
  input wire logic [sdct_pkg::COL_W-1:0] req_col,
  input wire logic [sdct_pkg::COL_W-1:0] req_len,
  output logic wdata_pull,
  input wire logic [sdct_pkg::DATA_W-1:0] wdata,
  input wire logic [sdct_pkg::MASK_W-1:0] wmask,
  output logic [sdct_pkg::DATA_W-1:0] rdata,
  output logic rdata_valid,
  input wire logic sref_req,
  output logic sref_active
);
  import sdct_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ACTW,
    S_BURST,
    S_TERM,
    S_RECOV,
    S_SREF,
    S_SREX
  } sdct_state_e;

  sdct_state_e state_ff, nxt_state;
  logic cke_ff, nxt_cke;
  logic [CMD_W-1:0] cmd_ff, nxt_cmd;
  logic [BANK_W-1:0] ba_ff, nxt_ba;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [MASK_W-1:0] dqm_ff, nxt_dqm;
  logic [DATA_W-1:0] dq_o_ff, nxt_dq_o;
  logic [MASK_W-1:0] dq_oe_ff, nxt_dq_oe;
  logic [WAIT_W-1:0] wait_ff, nxt_wait;
  logic [WAIT_W-1:0] rc_ff, nxt_rc;
  logic [REF_W-1:0] ref_cnt_ff, nxt_ref_cnt;
  logic ref_due_ff, nxt_ref_due;
  logic [COL_W-1:0] beats_ff, nxt_beats;
  logic [COL_W-1:0] col_ff, nxt_col;
  logic write_ff, nxt_write;
  logic first_ff, nxt_first;
  logic rd_beat_ff, nxt_rd_beat;
  logic [CAS_LAT-1:0] pipe_ff, nxt_pipe;
  logic ready_ff, nxt_ready;
  logic pull_ff, nxt_pull;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic sref_ff, nxt_sref;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing.
  always_comb begin
    nxt_state = state_ff;
    nxt_cke = cke_ff;
    nxt_cmd = CMD_NOP;
    nxt_ba = ba_ff;
    nxt_addr = addr_ff;
    nxt_dqm = '0;
    nxt_dq_o = dq_o_ff;
    nxt_dq_oe = '0;
    nxt_rd_beat = 1'b0;
    nxt_beats = beats_ff;
    nxt_col = col_ff;
    nxt_write = write_ff;
    nxt_first = first_ff;
    nxt_wait = (wait_ff != '0) ? wait_ff - 8'h01 : '0;
    nxt_rc = (rc_ff != '0) ? rc_ff - 8'h01 : '0;
    nxt_ref_cnt = ref_cnt_ff - 11'h001;
    nxt_ref_due = ref_due_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (req_valid && ready_ff) begin
          // The S_RECOV wait keeps a reused bank out until its precharge ends; the row cycle counter only spaces activates and refreshes a row cycle apart.
          nxt_cmd = CMD_ACT; // [RQ8]
          nxt_ba = req_bank;
          nxt_addr = req_row;
          nxt_write = req_write;
          nxt_col = req_col;
          nxt_beats = req_len;
          nxt_first = 1'b1;
          nxt_rc = RC_CYC - 8'h01; // [RQ5]
          nxt_wait = RCD_CYC - 8'h01; // [RQ5]
          nxt_state = S_ACTW;
        end else if (ref_due_ff && rc_ff == '0) begin
          nxt_cmd = CMD_REF; // [RQ10]
          nxt_ref_due = 1'b0;
          nxt_rc = RC_CYC - 8'h01;
        end else if (sref_req && rc_ff == '0) begin
          nxt_cmd = CMD_REF;
          nxt_cke = 1'b0;
          nxt_state = S_SREF;
        end
      end
      S_ACTW: begin
        if (wait_ff == '0) begin
          nxt_state = S_BURST;
        end
      end
      S_BURST: begin
        // One column command opens the burst; later beats ride on no-operation cycles.
        nxt_cmd = first_ff ? (write_ff ? CMD_WRITE : CMD_READ) : CMD_NOP; // [RQ9]
        nxt_addr = {1'b1, 2'b00, col_ff};
        nxt_first = 1'b0;
        nxt_rd_beat = ~write_ff;
        // On reads the mask floats the lanes of the beat fetched one cycle before this one.
        nxt_dqm = wmask; // [RQ1] [RQ2]
        if (write_ff) begin
          nxt_dq_o = wdata;
          nxt_dq_oe = '1;
        end
        if (beats_ff == '0) begin
          nxt_state = S_TERM;
        end else begin
          nxt_beats = beats_ff - 8'h01;
        end
      end
      S_TERM: begin
        // Data lines are released on the terminate edge since the memory drops that word.
        nxt_cmd = CMD_BST; // [RQ6] [RQ7]
        nxt_wait = write_ff ? (WR_CYC + RP_CYC - 8'h01) : (RP_CYC - 8'h01); // [RQ8]
        nxt_state = S_RECOV;
      end
      S_RECOV: begin
        if (wait_ff == '0) begin
          nxt_state = S_IDLE;
        end
      end
      S_SREF: begin
        if (!sref_req) begin
          nxt_cke = 1'b1; // [RQ3]
          nxt_wait = SREX_CYC - 8'h01; // [RQ4]
          nxt_state = S_SREX;
        end
      end
      S_SREX: begin
        // Two edges to start the exit plus a row cycle before new commands.
        if (wait_ff == '0) begin
          nxt_state = S_IDLE; // [RQ3] [RQ4]
        end
      end
    endcase
    // A due refresh set on the clearing cycle is kept.
    if (ref_cnt_ff == '0) begin
      nxt_ref_cnt = REFI_CYC - 11'h001; // [RQ10] [RQ11]
      nxt_ref_due = 1'b1;
    end
    nxt_ready = (nxt_state == S_IDLE) && (nxt_rc == '0) && !nxt_ref_due && !sref_req;
    nxt_pull = (nxt_state == S_BURST);
    nxt_sref = (nxt_state == S_SREF) || (nxt_state == S_SREX);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read capture: data returns CAS latency edges after the memory samples the beat.
  always_comb begin
    nxt_pipe = {pipe_ff[CAS_LAT-2:0], rd_beat_ff}; // [RQ6]
    nxt_rvalid = pipe_ff[CAS_LAT-1];
    nxt_rdata = pipe_ff[CAS_LAT-1] ? pins.dq : rdata_ff;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      cke_ff <= 1'b1;
      cmd_ff <= CMD_NOP;
      ba_ff <= '0;
      addr_ff <= '0;
      dqm_ff <= '0;
      dq_o_ff <= 32'h0000_0000;
      dq_oe_ff <= '0;
      wait_ff <= '0;
      rc_ff <= '0;
      ref_cnt_ff <= REFI_CYC - 11'h001;
      ref_due_ff <= 1'b0;
      beats_ff <= '0;
      col_ff <= '0;
      write_ff <= 1'b0;
      first_ff <= 1'b0;
      rd_beat_ff <= 1'b0;
      pipe_ff <= '0;
      ready_ff <= 1'b0;
      pull_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rvalid_ff <= 1'b0;
      sref_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cke_ff <= nxt_cke;
      cmd_ff <= nxt_cmd;
      ba_ff <= nxt_ba;
      addr_ff <= nxt_addr;
      dqm_ff <= nxt_dqm;
      dq_o_ff <= nxt_dq_o;
      dq_oe_ff <= nxt_dq_oe;
      wait_ff <= nxt_wait;
      rc_ff <= nxt_rc;
      ref_cnt_ff <= nxt_ref_cnt;
      ref_due_ff <= nxt_ref_due;
      beats_ff <= nxt_beats;
      col_ff <= nxt_col;
      write_ff <= nxt_write;
      first_ff <= nxt_first;
      rd_beat_ff <= nxt_rd_beat;
      pipe_ff <= nxt_pipe;
      ready_ff <= nxt_ready;
      pull_ff <= nxt_pull;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      sref_ff <= nxt_sref;
    end
  end

  assign pins.cke = cke_ff;
  assign pins.cmd = cmd_ff;
  assign pins.ba = ba_ff;
  assign pins.addr = addr_ff;
  assign pins.dqm = dqm_ff;
  assign pins.ctl_dq_o = dq_o_ff;
  assign pins.ctl_dq_oe = dq_oe_ff;
  assign req_ready = ready_ff;
  assign wdata_pull = pull_ff;
  assign rdata = rdata_ff;
  assign rdata_valid = rvalid_ff;
  assign sref_active = sref_ff;
endmodule // sdct_ctrl
`default_nettype wire

// ---- inc/sdct_pkg.sv ----
// Shared constants, command codes and timing counts for the SDRAM command timing pair.
`default_nettype none
package sdct_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry.
  localparam int DATA_W = 32;
  localparam int MASK_W = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 11;
  localparam int COL_W = 8;
  localparam int AP_BIT = 10;
  localparam int CMD_W = 4;
  localparam int WAIT_W = 8;
  localparam int REF_W = 11;

  // Command codes on {cs_n, ras_n, cas_n, we_n}.
  localparam logic [CMD_W-1:0] CMD_NOP = 4'h7;
  localparam logic [CMD_W-1:0] CMD_ACT = 4'h3;
  localparam logic [CMD_W-1:0] CMD_READ = 4'h5;
  localparam logic [CMD_W-1:0] CMD_WRITE = 4'h4;
  localparam logic [CMD_W-1:0] CMD_BST = 4'h6;
  localparam logic [CMD_W-1:0] CMD_PRE = 4'h2;
  localparam logic [CMD_W-1:0] CMD_REF = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Latencies counted in clocks.
  localparam int CAS_LAT = 3;
  localparam int MASK_READ_DISABLE_LATENCY = 2;
  localparam int MASK_WRITE_LATENCY = 0;
  localparam int COLUMN_COMMAND_SPACING = 1;
  localparam int SREX_EDGES = 2;

  // Clock period and speed grade; grade index 0..4 picks a column of the tables.
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int SPEED_GRADE = 3;
  localparam int unsigned ROW_CYCLE_TIME_PS [0:4] = '{60000, 63000, 66000, 70000, 72000};
  localparam int unsigned ROW_PRECHARGE_PS [0:4] = '{15000, 17000, 18000, 21000, 24000};
  localparam int unsigned ROW_TO_COL_PS [0:4] = '{15000, 16000, 16000, 16000, 16000};
  localparam int unsigned WRITE_RECOVERY_PS [0:4] = '{5000, 5500, 6000, 7000, 8000};
  localparam int unsigned REFRESH_PERIOD_MS = 32;
  localparam int unsigned REFRESH_CYCLES = 2048;

  // Least times round a fractional cycle up, never below one cycle.
  function automatic int unsigned cyc_up(input int unsigned ps);
    int unsigned q;
    q = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (q == 0) ? 1 : q;
  endfunction

  localparam logic [WAIT_W-1:0] RC_CYC = WAIT_W'(cyc_up(ROW_CYCLE_TIME_PS[SPEED_GRADE]));
  localparam logic [WAIT_W-1:0] RP_CYC = WAIT_W'(cyc_up(ROW_PRECHARGE_PS[SPEED_GRADE]));
  localparam logic [WAIT_W-1:0] RCD_CYC = WAIT_W'(cyc_up(ROW_TO_COL_PS[SPEED_GRADE]));
  localparam logic [WAIT_W-1:0] WR_CYC = WAIT_W'(cyc_up(WRITE_RECOVERY_PS[SPEED_GRADE]));
  localparam logic [WAIT_W-1:0] SREX_CYC = WAIT_W'(SREX_EDGES) + RC_CYC;
  // A longest interval rounds down.
  localparam logic [REF_W-1:0] REFI_CYC = REF_W'((64'(REFRESH_PERIOD_MS) * 64'd1000000000)
                                          / (64'(REFRESH_CYCLES) * 64'(CLK_PERIOD_PS)));

endpackage
`default_nettype wire

// ---- inc/sdct_if.sv ----
// Pin bundle between the controller and the memory, with data bus resolution.
`timescale 1ns/1ps
`default_nettype none
interface sdct_if;
  logic cke;
  logic [sdct_pkg::CMD_W-1:0] cmd;
  logic [sdct_pkg::BANK_W-1:0] ba;
  logic [sdct_pkg::ADDR_W-1:0] addr;
  logic [sdct_pkg::MASK_W-1:0] dqm;
  logic [sdct_pkg::DATA_W-1:0] ctl_dq_o;
  logic [sdct_pkg::MASK_W-1:0] ctl_dq_oe;
  logic [sdct_pkg::DATA_W-1:0] mem_dq_o;
  logic [sdct_pkg::MASK_W-1:0] mem_dq_oe;
  logic [sdct_pkg::DATA_W-1:0] dq;

  // An undriven byte lane reads as zero, standing in for a pulled bus.
  always_comb begin
    for (int b = 0; b < sdct_pkg::MASK_W; b++) begin
      if (mem_dq_oe[b]) begin
        dq[8*b +: 8] = mem_dq_o[8*b +: 8];
      end else if (ctl_dq_oe[b]) begin
        dq[8*b +: 8] = ctl_dq_o[8*b +: 8];
      end else begin
        dq[8*b +: 8] = 8'h00;
      end
    end
  end

  modport ctl (output cke, cmd, ba, addr, dqm, ctl_dq_o, ctl_dq_oe, input dq);
  modport mem (input cke, cmd, ba, addr, dqm, dq, output mem_dq_o, mem_dq_oe);
endinterface
`default_nettype wire

// ---- rtl/sdct_mem.sv ----
// Memory end: four-bank full-page burst array with mask, terminate and self refresh.
`timescale 1ns/1ps
`default_nettype none
module sdct_mem (
  input wire logic mclk,
  input wire logic rst_n,
  sdct_if.mem pins,
  output logic sref_active,
  output logic [3:0] bank_open
);
  import sdct_pkg::*;

  localparam int STG = CAS_LAT - 1;
  localparam int IDX_W = BANK_W + COL_W;

  logic [DATA_W-1:0] mem_q [0:(1<<IDX_W)-1];
  logic rd_ff, nxt_rd, wr_ff, nxt_wr, ap_ff, nxt_ap;
  logic [BANK_W-1:0] bank_ff, nxt_bank;
  logic [COL_W-1:0] col_ff, nxt_col;
  logic [3:0] open_ff, nxt_open;
  logic sref_ff, nxt_sref, seen_ff, nxt_seen;
  logic [MASK_W-1:0] dqm_q_ff;
  logic stg_vld_ff [0:STG-1];
  logic nxt_stg_vld [0:STG-1];
  logic [DATA_W-1:0] stg_dat_ff [0:STG-1];
  logic [DATA_W-1:0] nxt_stg_dat [0:STG-1];
  logic [DATA_W-1:0] dq_o_ff;
  logic [MASK_W-1:0] dq_oe_ff;
  logic we, fetch;
  logic [IDX_W-1:0] widx, fidx;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    nxt_ap = ap_ff;
    nxt_bank = bank_ff;
    nxt_col = col_ff;
    nxt_open = open_ff;
    nxt_sref = sref_ff;
    nxt_seen = seen_ff;
    we = 1'b0;
    fetch = 1'b0;
    widx = {bank_ff, col_ff};
    fidx = {bank_ff, col_ff};
    if (sref_ff) begin
      // Exit starts on the second rising edge that sees the clock enable high.
      if (pins.cke) begin
        nxt_seen = 1'b1; // [RQ3]
        if (seen_ff) begin
          nxt_sref = 1'b0; // [RQ3]
          nxt_seen = 1'b0;
        end
      end
    end else begin
      unique case (pins.cmd)
        CMD_ACT: nxt_open[pins.ba] = 1'b1;
        CMD_READ, CMD_WRITE: begin
          nxt_rd = (pins.cmd == CMD_READ);
          nxt_wr = (pins.cmd == CMD_WRITE);
          nxt_bank = pins.ba;
          nxt_ap = pins.addr[AP_BIT];
          nxt_col = pins.addr[COL_W-1:0] + 8'h01;
          widx = {pins.ba, pins.addr[COL_W-1:0]};
          fidx = widx;
          we = (pins.cmd == CMD_WRITE);
          fetch = (pins.cmd == CMD_READ);
        end
        CMD_BST: begin
          // The word on the terminate edge is not written, and fetching stops here.
          nxt_rd = 1'b0; // [RQ6]
          nxt_wr = 1'b0; // [RQ7]
          if (ap_ff) begin
            nxt_open[bank_ff] = 1'b0;
          end
        end
        CMD_PRE: begin
          nxt_rd = 1'b0;
          nxt_wr = 1'b0;
          if (pins.addr[AP_BIT]) begin
            nxt_open = 4'h0;
          end else begin
            nxt_open[pins.ba] = 1'b0;
          end
        end
        CMD_REF: nxt_sref = ~pins.cke;
        default: begin
          we = wr_ff;
          fetch = rd_ff;
          if (rd_ff || wr_ff) begin
            nxt_col = col_ff + 8'h01;
          end
        end
      endcase
    end
    nxt_stg_vld[0] = fetch;
    nxt_stg_dat[0] = mem_q[fidx];
    for (int i = 1; i < STG; i++) begin
      nxt_stg_vld[i] = stg_vld_ff[i-1];
      nxt_stg_dat[i] = stg_dat_ff[i-1];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      ap_ff <= 1'b0;
      bank_ff <= '0;
      col_ff <= '0;
      open_ff <= 4'h0;
      sref_ff <= 1'b0;
      seen_ff <= 1'b0;
      dqm_q_ff <= '0;
      dq_o_ff <= 32'h0000_0000;
      dq_oe_ff <= '0;
      for (int i = 0; i < STG; i++) begin
        stg_vld_ff[i] <= 1'b0;
        stg_dat_ff[i] <= 32'h0000_0000;
      end
    end else begin
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      ap_ff <= nxt_ap;
      bank_ff <= nxt_bank;
      col_ff <= nxt_col;
      open_ff <= nxt_open;
      sref_ff <= nxt_sref;
      seen_ff <= nxt_seen;
      dqm_q_ff <= pins.dqm;
      dq_o_ff <= stg_dat_ff[STG-1];
      // A mask seen on one edge blanks the lane for the sample two edges on.
      dq_oe_ff <= {MASK_W{stg_vld_ff[STG-1]}} & ~dqm_q_ff; // [RQ1]
      for (int i = 0; i < STG; i++) begin
        stg_vld_ff[i] <= nxt_stg_vld[i];
        stg_dat_ff[i] <= nxt_stg_dat[i];
      end
    end
  end

  // The array has no reset; a lane masked on the same edge keeps its old byte.
  always_ff @(posedge mclk) begin
    if (we) begin
      for (int b = 0; b < MASK_W; b++) begin
        if (!pins.dqm[b]) begin
          mem_q[widx][8*b +: 8] <= pins.dq[8*b +: 8]; // [RQ2]
        end
      end
    end
  end

  assign pins.mem_dq_o = dq_o_ff;
  assign pins.mem_dq_oe = dq_oe_ff;
  assign sref_active = sref_ff;
  assign bank_open = open_ff;
endmodule // sdct_mem
`default_nettype wire

// ---- dv/sdct_checker.sv ----
// Interface checker for the controller and memory ends of the SDRAM pair.
`timescale 1ns/1ps
`default_nettype none
module sdct_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic [sdct_pkg::CMD_W-1:0] cmd,
  input wire logic [sdct_pkg::MASK_W-1:0] dqm,
  input wire logic [sdct_pkg::MASK_W-1:0] ctl_dq_oe,
  input wire logic [sdct_pkg::MASK_W-1:0] mem_dq_oe
);
  import sdct_pkg::*;
  // A refresh may wait behind a full-page burst, so the gap limit has slack.
  localparam int REF_GAP_MAX = int'(REFI_CYC) + 300;
  logic rd_ff;
  logic nxt_rd_ff;
  logic [11:0] gap_ff;
  logic [11:0] nxt_gap_ff;
  logic col_cmd;
  assign col_cmd = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  always_comb begin
    nxt_rd_ff = (cmd == CMD_READ) ? 1'b1 : ((cmd == CMD_WRITE) ? 1'b0 : rd_ff);
    nxt_gap_ff = (cmd == CMD_REF || !cke) ? 12'h000 : gap_ff + {11'h000, gap_ff != 12'hfff};
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ff <= 1'b0;
      gap_ff <= 12'h000;
    end else begin
      rd_ff <= nxt_rd_ff;
      gap_ff <= nxt_gap_ff;
    end
  end
  //////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  read_mask_float_a: assert property ((dqm != 4'h0) |-> ##2 ((mem_dq_oe & $past(dqm, 2)) == 4'h0))
    else $error("masked lanes still driven two clocks on");
  sref_entry_a: assert property ($fell(cke) |-> cmd == CMD_REF)
    else $error("clock enable dropped without a refresh command");
  sref_exit_wait_a: assert property ($rose(cke) |-> (cmd == CMD_NOP)[*8])
    else $error("command issued inside self refresh exit wait");
  row_cycle_gap_a: assert property (cmd == CMD_ACT |=> (cmd != CMD_ACT)[*6])
    else $error("activates closer than seven clocks");
  read_stop_a: assert property ((cmd == CMD_BST) && rd_ff |-> ##2 (mem_dq_oe == 4'hf) ##1 (mem_dq_oe == 4'h0))
    else $error("read data did not stop three clocks after terminate");
  write_stop_a: assert property ((cmd == CMD_BST) && !rd_ff |-> $past(ctl_dq_oe) == 4'hf && ctl_dq_oe == 4'h0)
    else $error("write data driven on the terminate edge");
  precharge_gap_a: assert property (cmd == CMD_BST |=> (cmd != CMD_ACT)[*4])
    else $error("bank activated before precharge completed");
  column_spacing_a: assert property (col_cmd |=> !col_cmd)
    else $error("column commands back to back");
  refresh_gap_a: assert property (int'(gap_ff) <= REF_GAP_MAX)
    else $error("refresh interval exceeded");
  cover property ((cmd == CMD_BST) && rd_ff);
  cover property ((cmd == CMD_BST) && !rd_ff);
  cover property ($rose(cke));
  cover property ((cmd == CMD_REF) && cke);
  cover property ((dqm != 4'h0) && rd_ff);
endmodule // sdct_checker
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench driving the controller user side against the memory end.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sdct_pkg::*;
  logic mclk;
  logic rst_n;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic [BANK_W-1:0] req_bank;
  logic [ADDR_W-1:0] req_row;
  logic [COL_W-1:0] req_col;
  logic [COL_W-1:0] req_len;
  logic wdata_pull;
  logic [DATA_W-1:0] wdata;
  logic [MASK_W-1:0] wmask;
  logic [DATA_W-1:0] rdata;
  logic rdata_valid;
  logic sref_req;
  logic sref_active;
  logic mem_sref;
  logic [3:0] mem_open;
  logic [BANK_W-1:0] b;
  logic [COL_W-1:0] c;
  logic [COL_W-1:0] l;
  int n_mismatch;
  int n_checks;
  int seed;
  int n_ref;
  int r0;
  int n;
  int widx;
  logic [DATA_W-1:0] model [0:1023];
  logic [DATA_W-1:0] wbuf [0:255];
  logic [MASK_W-1:0] mbuf [0:255];
  logic [DATA_W-1:0] exp_q [$];

  sdct_if sdct_if_i ();
  sdct_ctrl sdct_ctrl_i (.mclk(mclk), .rst_n(rst_n), .pins(sdct_if_i.ctl),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank),
    .req_row(req_row), .req_col(req_col), .req_len(req_len), .wdata_pull(wdata_pull),
    .wdata(wdata), .wmask(wmask), .rdata(rdata), .rdata_valid(rdata_valid),
    .sref_req(sref_req), .sref_active(sref_active));
  sdct_mem sdct_mem_i (.mclk(mclk), .rst_n(rst_n), .pins(sdct_if_i.mem),
    .sref_active(mem_sref), .bank_open(mem_open));
  sdct_checker sdct_checker_i (.mclk(mclk), .rst_n(rst_n), .cke(sdct_if_i.cke),
    .cmd(sdct_if_i.cmd), .dqm(sdct_if_i.dqm), .ctl_dq_oe(sdct_if_i.ctl_dq_oe),
    .mem_dq_oe(sdct_if_i.mem_dq_oe));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic fill(input logic rand_mask);
    for (int k = 0; k < 256; k++) begin
      wbuf[k] = $random(seed);
      mbuf[k] = rand_mask ? 4'($random(seed)) : 4'h0;
    end
  endtask

  // A read mask in beat cycle k floats the lanes of beat k-1, so the last beat is never masked.
  function automatic logic [DATA_W-1:0] exp_beat(input logic [9:0] a, input int k, input int last);
    exp_beat = model[a];
    for (int y = 0; y < MASK_W; y++) begin
      if (k < last && mbuf[k+1][y]) exp_beat[8*y +: 8] = 8'h00;
    end
  endfunction

  // Expected memory image is updated up front; the next request waits for this one to drain.
  task automatic run(input logic wr, input logic [BANK_W-1:0] rb, input logic [COL_W-1:0] rc,
                     input logic [COL_W-1:0] rl);
    logic [9:0] a;
    for (int k = 0; k <= int'(rl); k++) begin
      a = {rb, 8'(rc + k)};
      for (int y = 0; y < MASK_W; y++) begin
        if (wr && !mbuf[k][y]) model[a][8*y +: 8] = wbuf[k][8*y +: 8];
      end
      if (!wr) exp_q.push_back(exp_beat(a, k, int'(rl)));
    end
    req_valid <= 1'b1;
    req_write <= wr;
    req_bank <= rb;
    req_row <= 11'($random(seed));
    req_col <= rc;
    req_len <= rl;
    widx <= 0;
    wdata <= wbuf[0];
    wmask <= mbuf[0];
    @(posedge mclk);
    while (req_ready !== 1'b1) @(posedge mclk);
    req_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("open banks in burst", 32'(4'h1 << rb), 32'(mem_open));
    while (req_ready !== 1'b1 || exp_q.size() != 0) @(posedge mclk);
    chk("open banks after burst", 32'h0000_0000, 32'(mem_open));
  endtask

  //////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (wdata_pull === 1'b1) begin
      wdata <= wbuf[8'(widx + 1)];
      wmask <= mbuf[8'(widx + 1)];
      widx <= widx + 1;
    end
    if (rdata_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("unexpected read beat: expected none, seen %h", rdata);
      end else begin
        chk("read data", exp_q.pop_front(), rdata);
      end
    end
    if (sdct_if_i.cmd === CMD_REF && sdct_if_i.cke === 1'b1) n_ref++;
  end

  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    seed = 26;
    n_mismatch = 0;
    n_checks = 0;
    n_ref = 0;
    widx = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_bank = '0;
    req_row = '0;
    req_col = '0;
    req_len = '0;
    wdata = '0;
    wmask = '0;
    sref_req = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    fill(1'b0);
    for (int i = 0; i < 4; i++) run(1'b1, 2'(i), 8'h00, 8'hff);
    run(1'b0, 2'h0, 8'h00, 8'hff);
    fill(1'b1);
    run(1'b1, 2'h1, 8'hfa, 8'h0a);
    run(1'b0, 2'h1, 8'hf9, 8'h0c);
    run(1'b1, 2'h3, 8'h7f, 8'h00);
    run(1'b0, 2'h3, 8'h7e, 8'h02);
    for (int i = 0; i < 12; i++) begin
      b = 2'($random(seed));
      c = 8'($random(seed));
      l = 8'($random(seed) & 15);
      fill(1'b1);
      run(1'b1, b, c, l);
      run(1'b0, b, c - 8'h01, l + 8'h02);
    end
    sref_req <= 1'b1;
    repeat (40) @(posedge mclk);
    chk("memory self refresh", 32'h0000_0001, 32'(mem_sref));
    chk("clock enable in self refresh", 32'h0000_0000, 32'(sdct_if_i.cke));
    sref_req <= 1'b0;
    n = 0;
    @(posedge mclk);
    while (sref_active === 1'b1 && n < 100) begin
      n++;
      @(posedge mclk);
    end
    chk("self refresh exit wait", 32'h0000_0001, 32'(n >= int'(SREX_CYC) && n < 100));
    chk("memory out of self refresh", 32'h0000_0000, 32'(mem_sref));
    run(1'b0, 2'h2, 8'h00, 8'h07);
    r0 = n_ref;
    repeat (3200) @(posedge mclk);
    chk("refreshes while idle", 32'h0000_0001, 32'(n_ref - r0 >= 2));
    wrap_up();
  end
endmodule // tb
`default_nettype wire
